// File: cfg_port_map.svh
// Offsets, reset values and timing counts for the serial configuration port.
`ifndef CFG_PORT_MAP_SVH
`define CFG_PORT_MAP_SVH

// Clock period of clk in nanoseconds (25 MHz).
`define CFG_CLK_PERIOD_NS 40
// Least low width of the reconfiguration reset in nanoseconds.
`define CFG_RECONF_MIN_NS 320
// Least low width in clk cycles, rounded up.
`define CFG_RECONF_MIN_CYC ((`CFG_RECONF_MIN_NS + `CFG_CLK_PERIOD_NS - 1) / `CFG_CLK_PERIOD_NS)

// Bit positions in the synchronised pin vector.
`define CFG_PIN_RECONF 0
`define CFG_PIN_CHIPSEL 1
`define CFG_PIN_SSL 2
`define CFG_PIN_CLK 3
`define CFG_PIN_DATA 4
`define CFG_PIN_DONE 5
`define CFG_PIN_EXTCLK 6
`define CFG_PIN_ACTIVE 7
`define CFG_PIN_USEEXT 8
`define CFG_PIN_DIV 9
`define CFG_PIN_W 11
// Idle levels of the pins: reset, slave select, clocks high; the rest low.
`define CFG_PIN_RESET 11'h04D

// Divide select codes.
`define CFG_DIV_ONE 2'h0
`define CFG_DIV_TWO 2'h1
`define CFG_DIV_FOUR 2'h2
`define CFG_DIV_EIGHT 2'h3

`endif

// File: cfg_port_pkg.sv
// Types shared by the configuration port modules.
`default_nettype none
package cfg_port_pkg;
   // Load sequence states, one-hot.
   typedef enum logic [3:0] {
      ST_LOAD = 4'h1,
      ST_RELEASE = 4'h2,
      ST_USER = 4'h4,
      ST_HOLD = 4'h8
   } cfg_state_type;
endpackage
`default_nettype wire

// File: pin_sync_if.sv
// Carrier between the pin synchroniser and the configuration port.
`default_nettype none
interface pin_sync_if #(parameter int W = 11);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport sync (input raw, output clean);
   modport user (output raw, input clean);
endinterface
`default_nettype wire

// File: pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`default_nettype none
module pin_sync #(
   parameter int W = 11,
   parameter logic [W-1:0] RESET_VALUE = '0
) (
   input wire logic clk,
   input wire logic rst,
   pin_sync_if.sync pins
);
   logic [W-1:0] stage1_r, stage2_r, stage3_r, clean_r;
   logic [W-1:0] clean_nxt;

   // Only bits whose last two stages agree may update; stage one feeds stage two alone.
   always_comb begin
      clean_nxt = clean_r;
      for (int i = 0; i < W; i++) begin
         if (stage2_r[i] == stage3_r[i]) begin
            clean_nxt[i] = stage3_r[i];
         end
      end
   end

   // Register the chain.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage1_r <= RESET_VALUE;
         stage2_r <= RESET_VALUE;
         stage3_r <= RESET_VALUE;
         clean_r <= RESET_VALUE;
      end else begin
         stage1_r <= pins.raw;
         stage2_r <= stage1_r;
         stage3_r <= stage2_r;
         clean_r <= clean_nxt;
      end
   end

   assign pins.clean = clean_r;
endmodule
`default_nettype wire

// File: bitstream_config_port.sv
// Serial bitstream configuration port: passive and active loading, done line and reconfiguration.
//
// Functional notes
// RQ1 - Host keeps chip select high throughout.
// RQ2 - Host keeps slave select low throughout.
// RQ3 - Data taken only on configuration clock edges.
// RQ4 - Host stops clock when data invalid.
// RQ5 - Host resumes with the next bit.
// RQ6 - Host gives 100 clocks after last bit.
// RQ7 - Host waits 32 us after reset release.
// RQ8 - Active mode divides clock by 1/2/4/8.
// RQ9 - Active mode may use external clock.
// RQ10 - Mode 3: idle high, sample rising.
// RQ11 - Host should avoid shared SPI slaves.
// RQ12 - Long reset low then release reconfigures.
// RQ13 - Release done line, enter user mode.
// RQ14 - Chip select low means not selected.
`include "cfg_port_map.svh"
`default_nettype none
module bitstream_config_port
   import cfg_port_pkg::*;
#(
   parameter int BITSTREAM_BITS = 1024,
   parameter int WORD_W = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic reconfigResetLow,
   input wire logic chipSelect,
   input wire logic port_slave_select_low,
   input wire logic bitstream_clock_in,
   input wire logic bitstream_data_in,
   input wire logic externalClock,
   input wire logic activeMode,
   input wire logic useExternalClock,
   input wire logic [1:0] divideSelect,
   input wire logic load_complete_flag_in,
   output logic bitstream_clock_out,
   output logic bitstream_clock_oe,
   output logic load_complete_flag_out,
   output logic load_complete_flag_oe,
   output logic [WORD_W-1:0] configWord,
   output logic configWordValid,
   output logic userMode
);
   localparam int CNT_W = $clog2(BITSTREAM_BITS + 1);
   localparam int WCNT_W = $clog2(WORD_W);
   localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(BITSTREAM_BITS - 1);
   localparam logic [3:0] RECONF_MIN = 4'(`CFG_RECONF_MIN_CYC);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation.

   pin_sync_if #(.W(`CFG_PIN_W)) pins ();

   assign pins.raw = {divideSelect, useExternalClock, activeMode, externalClock,
                      load_complete_flag_in, bitstream_data_in, bitstream_clock_in,
                      port_slave_select_low, chipSelect, reconfigResetLow};

   pin_sync #(.W(`CFG_PIN_W), .RESET_VALUE(`CFG_PIN_RESET)) u_sync (
      .clk(clk),
      .rst(rst),
      .pins(pins)
   );

   logic reconfLow, chipSel, slaveSelLow, clkIn, dataIn, doneLine, extClk, active, useExt;
   logic [1:0] divSel;
   assign reconfLow = !pins.clean[`CFG_PIN_RECONF];
   assign chipSel = pins.clean[`CFG_PIN_CHIPSEL];
   assign slaveSelLow = pins.clean[`CFG_PIN_SSL];
   assign clkIn = pins.clean[`CFG_PIN_CLK];
   assign dataIn = pins.clean[`CFG_PIN_DATA];
   assign doneLine = pins.clean[`CFG_PIN_DONE];
   assign extClk = pins.clean[`CFG_PIN_EXTCLK];
   assign active = pins.clean[`CFG_PIN_ACTIVE];
   assign useExt = pins.clean[`CFG_PIN_USEEXT];
   assign divSel = pins.clean[`CFG_PIN_DIV +: 2];

   ////////////////////////////////////////////////////////////////////////////
   // State.

   cfg_state_type state_r, state_nxt;
   logic [CNT_W-1:0] bitCnt_r, bitCnt_nxt;
   logic [WCNT_W-1:0] wordCnt_r, wordCnt_nxt;
   logic [WORD_W-1:0] shift_r, shift_nxt, word_r, word_nxt;
   logic wordValid_r, wordValid_nxt;
   logic [3:0] lowCnt_r, lowCnt_nxt;
   logic [2:0] divCnt_r, divCnt_nxt;
   logic genClk_r, genClk_nxt;
   logic clkOe_r, clkOe_nxt;
   logic doneOe_r, doneOe_nxt;
   logic user_r, user_nxt;
   logic prevClkIn_r, prevExt_r;
   logic [2:0] halfLast;
   logic internalRun, genRise, passiveRise, extRise, captureEdge, enterHold;

   // Last divider count of each half period of the generated clock; output runs at clk / (2 * ratio).
   always_comb begin
      if (divSel == `CFG_DIV_ONE) begin
         halfLast = 3'h0;
      end else if (divSel == `CFG_DIV_TWO) begin
         halfLast = 3'h1;
      end else if (divSel == `CFG_DIV_FOUR) begin
         halfLast = 3'h3;
      end else begin
         halfLast = 3'h7;
      end
   end

   // Capture events; a stalled clock yields no edge, so no bit is taken.
   assign internalRun = (state_r == ST_LOAD) && active && !useExt;
   assign genRise = internalRun && (divCnt_r == halfLast) && !genClk_r; // [RQ8]
   assign extRise = extClk && !prevExt_r; // [RQ9]
   assign passiveRise = clkIn && !prevClkIn_r; // [RQ10]
   always_comb begin
      captureEdge = 1'b0;
      if (state_r == ST_LOAD && chipSel) begin // [RQ14]
         if (active) begin
            captureEdge = useExt ? extRise : genRise; // [RQ3]
         end else begin
            captureEdge = passiveRise && !slaveSelLow; // [RQ3]
         end
      end
   end
   assign enterHold = reconfLow && (lowCnt_r == RECONF_MIN - 4'h1);

   // Next-state logic for the load sequence, clock generator and done line.
   always_comb begin
      state_nxt = state_r;
      bitCnt_nxt = bitCnt_r;
      wordCnt_nxt = wordCnt_r;
      shift_nxt = shift_r;
      word_nxt = word_r;
      wordValid_nxt = 1'b0;
      lowCnt_nxt = reconfLow ? lowCnt_r : 4'h0;
      divCnt_nxt = 3'h0;
      genClk_nxt = 1'b1; // [RQ10]
      if (reconfLow && lowCnt_r != RECONF_MIN) begin
         lowCnt_nxt = lowCnt_r + 4'h1;
      end
      // The generated clock only runs while loading; a divider of one toggles every cycle.
      if (internalRun) begin
         genClk_nxt = genClk_r;
         divCnt_nxt = divCnt_r + 3'h1;
         if (divCnt_r == halfLast) begin
            divCnt_nxt = 3'h0;
            genClk_nxt = !genClk_r; // [RQ8]
         end
      end
      if (captureEdge) begin
         shift_nxt = {shift_r[WORD_W-2:0], dataIn}; // [RQ3]
         bitCnt_nxt = bitCnt_r + CNT_W'(1);
         wordCnt_nxt = wordCnt_r + WCNT_W'(1);
         if (wordCnt_r == WCNT_W'(WORD_W - 1)) begin
            word_nxt = {shift_r[WORD_W-2:0], dataIn};
            wordValid_nxt = 1'b1;
         end
      end
      case (state_r)
         ST_LOAD: begin
            if (captureEdge && bitCnt_r == LAST_BIT) begin
               state_nxt = ST_RELEASE;
            end
         end
         ST_RELEASE: begin
            // Another party may hold the line low to delay user mode.
            if (doneLine) begin
               state_nxt = ST_USER; // [RQ13]
            end
         end
         ST_USER: begin
            state_nxt = ST_USER;
         end
         ST_HOLD: begin
            if (!reconfLow) begin
               state_nxt = ST_LOAD; // [RQ12]
               bitCnt_nxt = '0;
               wordCnt_nxt = '0;
            end
         end
         default: begin
            state_nxt = ST_HOLD;
         end
      endcase
      if (enterHold) begin
         state_nxt = ST_HOLD; // [RQ12]
      end
      clkOe_nxt = !(state_nxt == ST_LOAD && active && !useExt);
      doneOe_nxt = (state_nxt == ST_RELEASE) || (state_nxt == ST_USER); // [RQ13]
      user_nxt = (state_nxt == ST_USER);
   end

   // Registers; power-on reset starts a load straight away.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_LOAD;
         bitCnt_r <= '0;
         wordCnt_r <= '0;
         shift_r <= '0;
         word_r <= '0;
         wordValid_r <= 1'b0;
         lowCnt_r <= 4'h0;
         divCnt_r <= 3'h0;
         genClk_r <= 1'b1;
         clkOe_r <= 1'b1;
         doneOe_r <= 1'b0;
         user_r <= 1'b0;
         prevClkIn_r <= 1'b1;
         prevExt_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         bitCnt_r <= bitCnt_nxt;
         wordCnt_r <= wordCnt_nxt;
         shift_r <= shift_nxt;
         word_r <= word_nxt;
         wordValid_r <= wordValid_nxt;
         lowCnt_r <= lowCnt_nxt;
         divCnt_r <= divCnt_nxt;
         genClk_r <= genClk_nxt;
         clkOe_r <= clkOe_nxt;
         doneOe_r <= doneOe_nxt;
         user_r <= user_nxt;
         prevClkIn_r <= clkIn;
         prevExt_r <= extClk;
      end
   end

   // The done pin is open drain: it only ever drives low, so its data stays zero.
   assign bitstream_clock_out = genClk_r;
   assign bitstream_clock_oe = clkOe_r;
   assign load_complete_flag_out = 1'b0;
   assign load_complete_flag_oe = doneOe_r;
   assign configWord = word_r;
   assign configWordValid = wordValid_r;
   assign userMode = user_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   sequence reconfHeldLow;
      reconfLow [*8];
   endsequence

   chk_idle_no_capture: assert property (@(posedge clk) disable iff (rst) // [RQ3]
      (state_r == ST_LOAD && !captureEdge && !enterHold) |=> $stable(bitCnt_r))
      else $error("Bit counted without a clock edge.");

   chk_divider_period: assert property (@(posedge clk) disable iff (rst) // [RQ8]
      (genClk_r != $past(genClk_r) && $past(internalRun) && internalRun)
      |-> $past(divCnt_r) == $past(halfLast))
      else $error("Generated clock toggled at the wrong count.");

   chk_external_clock: assert property (@(posedge clk) disable iff (rst) // [RQ9]
      (state_r == ST_LOAD && active && useExt && chipSel && extRise && !enterHold)
      |=> bitCnt_r == $past(bitCnt_r) + CNT_W'(1))
      else $error("External clock edge did not take a bit.");

   chk_clock_idle_high: assert property (@(posedge clk) disable iff (rst) // [RQ10]
      (state_r != ST_LOAD && $past(state_r) != ST_LOAD) |-> bitstream_clock_out)
      else $error("Configuration clock not idle high.");

   chk_reconfig_start: assert property (@(posedge clk) disable iff (rst) // [RQ12]
      reconfHeldLow |=> state_r == ST_HOLD)
      else $error("Long reset low did not enter hold.");

   chk_done_user: assert property (@(posedge clk) disable iff (rst) // [RQ13]
      $rose(user_r) |-> $past(doneLine) && doneOe_r && bitCnt_r == CNT_W'(BITSTREAM_BITS))
      else $error("User mode entered without completed load and high done line.");

   chk_unselected: assert property (@(posedge clk) disable iff (rst) // [RQ14]
      (state_r == ST_LOAD && !chipSel && !enterHold) |=> $stable(bitCnt_r))
      else $error("Bit taken while chip select low.");

   chk_hold_release: assert property (@(posedge clk) disable iff (rst) // [RQ12]
      (state_r == ST_HOLD && !reconfLow) |=> state_r == ST_LOAD && bitCnt_r == '0)
      else $error("Reset release did not restart the load.");
endmodule
`default_nettype wire

// File: bitstream_config_port_notes_unused.sv
// Intentionally empty compilation unit for the configuration port.
`default_nettype none
`default_nettype wire

// File: bitstream_host_model.sv
// Host model that loads a bitstream into the port over the passive serial link.
`default_nettype none
module bitstream_host_model (
   input wire logic clk,
   output logic chipSelect,
   output logic port_slave_select_low,
   output logic hostClock,
   output logic hostData,
   output logic reconfigResetLow,
   output logic holdDoneLow
);
   timeunit 1ns;
   timeprecision 1ns;
   // Each clock level lasts six cycles so that the pin synchroniser sees it settle.
   localparam int HALF = 6;

   // Pins start idle; this host is the only slave master on the link.
   initial begin
      chipSelect = 1'b0;
      port_slave_select_low = 1'b1;
      hostClock = 1'b1;
      hostData = 1'b0;
      reconfigResetLow = 1'b1;
      holdDoneLow = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Data changes while the clock is low; the port samples it on the rise.
   task automatic shiftBit(input logic b);
      @(negedge clk);
      hostClock = 1'b0;
      hostData = b;
      repeat (HALF) @(negedge clk);
      hostClock = 1'b1;
      repeat (HALF - 1) @(negedge clk);
   endtask

   // Sends one byte first bit first; the clock then stands high until the next call.
   task automatic sendByte(input logic [7:0] v, input logic cs, input logic sslLow);
      chipSelect = cs;
      port_slave_select_low = sslLow;
      for (int i = 7; i >= 0; i--) begin
         shiftBit(v[i]);
      end
      hostData = ~hostData; // A released line shows no stale value.
   endtask

   // Keeps the clock running after the last bit so the port can finish.
   task automatic trailClocks();
      for (int i = 0; i < 100; i++) begin
         shiftBit(~hostData);
      end
   endtask

   // Pulses the reconfiguration reset low, then waits 32 us (800 cycles) before data.
   task automatic pulseReset(input int lowCycles);
      reconfigResetLow = 1'b0;
      repeat (lowCycles) @(negedge clk);
      reconfigResetLow = 1'b1;
      repeat (800) @(negedge clk);
   endtask

   // Holding the done line low delays the port's entry into user mode.
   task automatic setHold(input logic h);
      holdDoneLow = h;
   endtask

   // Data level used when the port is clocked from elsewhere.
   task automatic setData(input logic b);
      hostData = b;
   endtask
endmodule
`default_nettype wire

// File: tb_spi_bitstream_config_port.sv
// Self-checking testbench of the serial bitstream configuration port.
`default_nettype none
module tb_spi_bitstream_config_port;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BITS = 64;
   localparam int WW = 8;
   logic clk, rst, externalClock, activeMode, useExternalClock;
   logic [1:0] divideSelect;
   logic clockOut, clockOe, doneOut, doneOe, valid, userMode;
   logic [WW-1:0] word, lastWord;
   wire logic cs, sslLow, hostClock, hostData, resetLow, holdDoneLow;
   int badCount, checked, wordCount, cycles;

   // The clock pin follows whoever drives it; the done line has a pull-up.
   wire logic pinClock = clockOe ? hostClock : clockOut;
   wire logic pinDone = doneOe & ~holdDoneLow;

   ////////////////////////////////////////////////////////////////////////////////
   bitstream_host_model i_bitstream_host_model (.clk(clk), .chipSelect(cs),
      .port_slave_select_low(sslLow), .hostClock(hostClock), .hostData(hostData),
      .reconfigResetLow(resetLow), .holdDoneLow(holdDoneLow));

   bitstream_config_port #(.BITSTREAM_BITS(BITS), .WORD_W(WW)) i_bitstream_config_port (
      .clk(clk), .rst(rst), .reconfigResetLow(resetLow), .chipSelect(cs),
      .port_slave_select_low(sslLow), .bitstream_clock_in(pinClock),
      .bitstream_data_in(hostData), .externalClock(externalClock), .activeMode(activeMode),
      .useExternalClock(useExternalClock), .divideSelect(divideSelect),
      .load_complete_flag_in(pinDone), .bitstream_clock_out(clockOut),
      .bitstream_clock_oe(clockOe), .load_complete_flag_out(doneOut),
      .load_complete_flag_oe(doneOe), .configWord(word), .configWordValid(valid),
      .userMode(userMode));

   // The 40 ns clock.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Words are captured here because the valid pulse lasts a single cycle.
   always @(posedge clk) begin
      if (valid === 1'b1) begin
         lastWord <= word;
         wordCount <= wordCount + 1;
      end
   end

   // A run longer than about two and a half times the expected length counts as a hang.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 12000) begin
         badCount++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         badCount++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Selects the loading mode; both pins are synchronised, so allow a few cycles.
   task automatic setMode(input logic act, input logic ext);
      activeMode = act;
      useExternalClock = ext;
   endtask

   task automatic report_and_stop();
      if (badCount == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Counts cycles between two rises of the generated clock, after syncing to one.
   task automatic measure(output int n);
      logic p;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            p = clockOut;
            @(negedge clk);
            n++;
         end while (!(p === 1'b0 && clockOut === 1'b1));
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic testDeselect();
      i_bitstream_host_model.sendByte(8'h3C, 1'b0, 1'b0);
      i_bitstream_host_model.sendByte(8'hC3, 1'b1, 1'b1);
      repeat (30) @(negedge clk);
      check("words while deselected", 32'h0, 32'(wordCount));
   endtask

   // A full load with a pause, then a held done line and trailing clocks.
   task automatic testPassive();
      logic [7:0] v;
      i_bitstream_host_model.setHold(1'b1);
      for (int i = 0; i < 8; i++) begin
         v = {i[3:0], ~i[3:0]};
         i_bitstream_host_model.sendByte(v, 1'b1, 1'b0);
         if (i == 3) repeat (20) @(negedge clk); // Clock stands high here.
         repeat (6) @(negedge clk);
         check("word", {24'h0, v}, {24'h0, lastWord});
         check("word count", 32'(i + 1), 32'(wordCount));
      end
      check("done released", 32'h1, {31'h0, doneOe});
      repeat (20) @(negedge clk);
      check("user mode held", 32'h0, {31'h0, userMode});
      i_bitstream_host_model.setHold(1'b0);
      repeat (12) @(negedge clk);
      check("user mode", 32'h1, {31'h0, userMode});
      i_bitstream_host_model.trailClocks();
      check("words after load", 32'h8, 32'(wordCount));
   endtask

   task automatic testReconfig();
      i_bitstream_host_model.pulseReset(4);
      check("short pulse ignored", 32'h1, {31'h0, userMode});
      i_bitstream_host_model.pulseReset(20);
      check("user mode cleared", 32'h0, {31'h0, userMode});
      check("done pulled low", 32'h0, {31'h0, doneOe});
   endtask

   // Each divide code gives a generated clock period of twice its ratio.
   task automatic testActive();
      int n;
      i_bitstream_host_model.setData(1'b1);
      setMode(1'b1, 1'b0);
      for (int d = 0; d < 4; d++) begin
         divideSelect = 2'(d);
         repeat (8) @(negedge clk);
         measure(n);
         check("period", 32'(2 << d), 32'(n));
         check("clock driven", 32'h0, {31'h0, clockOe});
      end
      check("active word", 32'hFF, {24'h0, lastWord});
   endtask

   task automatic testExternal();
      logic [7:0] v;
      v = 8'hA5;
      setMode(1'b1, 1'b1);
      i_bitstream_host_model.pulseReset(20);
      for (int i = 7; i >= 0; i--) begin
         externalClock = 1'b0;
         i_bitstream_host_model.setData(v[i]);
         repeat (6) @(negedge clk);
         externalClock = 1'b1;
         repeat (6) @(negedge clk);
      end
      check("external word", 32'hA5, {24'h0, lastWord});
      check("clock released", 32'h1, {31'h0, clockOe});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      externalClock = 1'b1;
      setMode(1'b0, 1'b0);
      divideSelect = 2'h0;
      badCount = 0;
      checked = 0;
      wordCount = 0;
      cycles = 0;
      lastWord = '0;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (6) @(negedge clk);
      check("done after reset", 32'h0, {31'h0, doneOe});
      check("clock pin released", 32'h1, {31'h0, clockOe});
      check("done data low", 32'h0, {31'h0, doneOut});
      testDeselect();
      testPassive();
      testReconfig();
      testActive();
      testExternal();
      report_and_stop();
   end
endmodule
`default_nettype wire
